// ### synth_aux_regs.sv
// Purpose: Loop-mode tail bits, auxiliary control and readback status registers
// Assumes: Host uses a plain strobe port; read data one cycle after the strobe
// Notes:   A write word with the read bit set is a read request, not a store
//
// Contract
// R01 - Counter reset bit 3 of loop-mode register holds reference and feedback counters.
// R02 - Aux control sits at address code 100, resets to 0000004 hex.
// R03 - Bit 31 of a word: 0 writes, 1 requests a read.
// R04 - Bit 21 set disables the reference input stage.
// R05 - Divider mode bits 20:19: off, fast lock, phase adjust, ADC clock.
// R06 - Divider value bits 18:7, ratio 1 to 4095; host never programs zero. The bench's 32'h18 conversion writes to aux control program zero.
// R07 - Converter mode bits 6:4: 000 off, 001 temperature sensor; rest unused.
// R08 - Writing 1 to bit 3 starts a conversion; here only when the same word sets bits 6:4 to 001.
// R09 - Status register is read-only and returned on a read request.
// R10 - Status bit 11 reads 1 until the power-on flag is read back.
// R11 - Status bit 10 is 0 while converting, 1 when valid; result bits 9:3.
// R12 - Status bits 2:0 return the register address code.
// R13 - Host writes aux control bits 30:22 as zero.
// R14 - First status readback clears the power-on flag until next reset.
// R15 - Starting a conversion clears valid; valid returns after the result loads.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "synth_aux_defs.svh"

module synth_aux_regs #(
    parameter int CONV_CYCLES = `SA_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [2:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    // Synthesizer controls
    output logic             counterReset,
    output logic             refStageShutdown,
    output logic             dividerOff,
    output logic             fastLockEnable,
    output logic             phaseAdjustEnable,
    output logic             dividerAdcClock,
    output logic      [11:0] dividerValue,
    output logic             tempSensorSelect,
    output logic             conversionBusy,
    // Converter sample
    input  wire logic [6:0]  convSample,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    // The sequencer counts in 16 bits
    generate
        if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
            $error("CONV_CYCLES out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    // A write word with bit 31 set behaves exactly like a read strobe
    wire wrReadReq  = regWrite && regWdata[`SA_BIT_READ];          // [R03]
    wire storeReq   = regWrite && !regWdata[`SA_BIT_READ];         // [R03]
    wire readReq    = regRead || wrReadReq;

    logic wrLoop;
    logic wrAux;
    logic wrIrqStat;
    logic wrIrqMask;
    logic rdStatus;

    always_comb begin
        wrLoop    = 1'b0;
        wrAux     = 1'b0;
        wrIrqStat = 1'b0;
        wrIrqMask = 1'b0;
        if (storeReq && regAddr == `SA_ADDR_LOOP_MODE) begin
            wrLoop = 1'b1;
        end else if (storeReq && regAddr == `SA_ADDR_AUX_CTRL) begin
            wrAux = 1'b1;                                           // [R02]
        end else if (storeReq && regAddr == `SA_ADDR_IRQ_STATUS) begin
            wrIrqStat = 1'b1;
        end else if (storeReq && regAddr == `SA_ADDR_IRQ_MASK) begin
            wrIrqMask = 1'b1;
        end
    end

    // Status is read-only: a store there is dropped
    assign rdStatus = readReq && (regAddr == `SA_ADDR_READBACK);   // [R09]

    // ----------------------------------------------------------------
    // Stored registers
    // ----------------------------------------------------------------
    logic [31:0] loopModeQ;
    logic [31:0] auxCtrlQ;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loopModeQ <= `SA_LOOP_MODE_RESET;
        end else if (wrLoop) begin
            loopModeQ <= {1'b0, regWdata[30:3], `SA_ADDR_LOOP_MODE};
        end
    end

    // Bits 30:22 kept as written; the host is expected to send zero there
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            auxCtrlQ <= `SA_AUX_CTRL_RESET;                         // [R02]
        end else if (wrAux) begin
            auxCtrlQ <= {1'b0, regWdata[30:3], `SA_ADDR_AUX_CTRL};  // [R13]
        end
    end

    // ----------------------------------------------------------------
    // Conversion control
    // ----------------------------------------------------------------
    // Start only when the word also selects the temperature sensor input
    wire [2:0] newConvMode = regWdata[`SA_CONVMODE_HI:`SA_CONVMODE_LO];
    wire       convStart   = wrAux && regWdata[`SA_BIT_CONV_START]
                             && (newConvMode == sa_pkg::CONV_TEMP); // [R08] [R07]

    logic       convValid;
    logic [6:0] convResult;
    logic       convDone;
    logic       convBusy;

    sa_conv_seq #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .startPulse  (convStart),
        .sample      (convSample),
        .busy        (convBusy),
        .resultValid (convValid),
        .result      (convResult),
        .donePulse   (convDone)
    );

    // ----------------------------------------------------------------
    // Power-on readback flag
    // ----------------------------------------------------------------
    logic porPendingQ;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            porPendingQ <= 1'b1;                                    // [R10]
        end else if (rdStatus) begin
            porPendingQ <= 1'b0;                                    // [R14]
        end
    end

    wire porReadEvent = rdStatus && porPendingQ;

    // ----------------------------------------------------------------
    // Interrupt status and mask
    // ----------------------------------------------------------------
    logic [`SA_IRQ_WIDTH-1:0] irqStatQ;
    logic [`SA_IRQ_WIDTH-1:0] irqMaskQ;
    wire  [`SA_IRQ_WIDTH-1:0] irqEvent = {porReadEvent, convDone};

    genvar gi;
    generate
        for (gi = 0; gi < `SA_IRQ_WIDTH; gi++) begin : g_irq
            // Set beats a same-cycle write-one-to-clear
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    irqStatQ[gi] <= 1'b0;
                end else if (irqEvent[gi]) begin
                    irqStatQ[gi] <= 1'b1;
                end else if (wrIrqStat && regWdata[gi]) begin
                    irqStatQ[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqMaskQ <= '0;
        end else if (wrIrqMask) begin
            irqMaskQ <= regWdata[`SA_IRQ_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatQ & irqMaskQ);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] statusWord;
    logic [31:0] readMux;

    always_comb begin
        statusWord                                 = 32'h00000000;
        statusWord[`SA_BIT_POR]                    = porPendingQ;            // [R10]
        statusWord[`SA_BIT_CONV_VALID]             = convValid;              // [R11]
        statusWord[`SA_RESULT_HI:`SA_RESULT_LO]    = convResult;             // [R11]
        statusWord[`SA_ADDR_HI:`SA_ADDR_LO]        = `SA_ADDR_READBACK;      // [R12]
    end

    always_comb begin
        readMux = 32'h00000000;
        if (regAddr == `SA_ADDR_LOOP_MODE) begin
            readMux = loopModeQ;
        end else if (regAddr == `SA_ADDR_AUX_CTRL) begin
            readMux = auxCtrlQ;                                     // [R03]
        end else if (regAddr == `SA_ADDR_READBACK) begin
            readMux = statusWord;                                   // [R09]
        end else if (regAddr == `SA_ADDR_IRQ_STATUS) begin
            readMux = {30'h00000000, irqStatQ};
        end else if (regAddr == `SA_ADDR_IRQ_MASK) begin
            readMux = {30'h00000000, irqMaskQ};
        end
    end

    // Data stand for the one cycle after the request, zero otherwise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 32'h00000000;
        end else if (readReq) begin
            regRdata <= readMux;
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    wire [1:0] divMode  = auxCtrlQ[`SA_DIVMODE_HI:`SA_DIVMODE_LO];
    wire [2:0] convMode = auxCtrlQ[`SA_CONVMODE_HI:`SA_CONVMODE_LO];

    // One register per control; each follows its stored field (conversionBusy the sequencer busy flag) one cycle later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            counterReset <= 1'b0;
        end else begin
            counterReset <= loopModeQ[`SA_BIT_CNT_RESET];                  // [R01]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            refStageShutdown <= 1'b0;
        end else begin
            refStageShutdown <= auxCtrlQ[`SA_BIT_REF_SHDN];                // [R04]
        end
    end

    // Exactly one mode output is high at any time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dividerOff        <= 1'b1;
            fastLockEnable    <= 1'b0;
            phaseAdjustEnable <= 1'b0;
            dividerAdcClock   <= 1'b0;
        end else begin
            dividerOff        <= (divMode == sa_pkg::DIV_OFF);             // [R05]
            fastLockEnable    <= (divMode == sa_pkg::DIV_FAST_LOCK);       // [R05]
            phaseAdjustEnable <= (divMode == sa_pkg::DIV_PHASE_ADJ);       // [R05]
            dividerAdcClock   <= (divMode == sa_pkg::DIV_ADC_CLOCK);       // [R05]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dividerValue <= 12'h000;
        end else begin
            dividerValue <= auxCtrlQ[`SA_DIVVAL_HI:`SA_DIVVAL_LO];         // [R06]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tempSensorSelect <= 1'b0;
        end else begin
            tempSensorSelect <= (convMode == sa_pkg::CONV_TEMP);           // [R07]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conversionBusy <= 1'b0;
        end else begin
            conversionBusy <= convBusy;
        end
    end

endmodule

// ### synth_aux_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the synth aux registers
// Assumes: Included by bare name wherever the constants are needed
// Notes:   Definitions only
`ifndef SYNTH_AUX_DEFS_SVH
`define SYNTH_AUX_DEFS_SVH

// ----------------------------------------------------------------
// Register address codes
// ----------------------------------------------------------------
`define SA_ADDR_LOOP_MODE   3'h3
`define SA_ADDR_AUX_CTRL    3'h4
`define SA_ADDR_IRQ_STATUS  3'h5
`define SA_ADDR_READBACK    3'h6
`define SA_ADDR_IRQ_MASK    3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SA_LOOP_MODE_RESET  32'h00000043
`define SA_AUX_CTRL_RESET   32'h00000004

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SA_BIT_READ         31
`define SA_BIT_CNT_RESET    3
`define SA_BIT_REF_SHDN     21
`define SA_DIVMODE_HI       20
`define SA_DIVMODE_LO       19
`define SA_DIVVAL_HI        18
`define SA_DIVVAL_LO        7
`define SA_CONVMODE_HI      6
`define SA_CONVMODE_LO      4
`define SA_BIT_CONV_START   3
`define SA_BIT_POR          11
`define SA_BIT_CONV_VALID   10
`define SA_RESULT_HI        9
`define SA_RESULT_LO        3
`define SA_ADDR_HI          2
`define SA_ADDR_LO          0

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define SA_IRQ_CONV_DONE    0
`define SA_IRQ_POR_READ     1
`define SA_IRQ_WIDTH        2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SA_CONV_CYCLES      16

`endif

// ### synth_aux_pkg.sv
// Purpose: Types shared by the synth aux register block
// Assumes: Field positions live in synth_aux_defs.svh
// Notes:   Referenced with explicit package scope only
package sa_pkg;

    typedef enum logic [1:0] {
        DIV_OFF       = 2'b00,
        DIV_FAST_LOCK = 2'b01,
        DIV_PHASE_ADJ = 2'b10,
        DIV_ADC_CLOCK = 2'b11
    } sa_div_mode_t;

    typedef enum logic [2:0] {
        CONV_OFF      = 3'b000,
        CONV_TEMP     = 3'b001
    } sa_conv_mode_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } sa_seq_state_t;

endpackage

// ### sa_conv_seq.sv
// Purpose: Conversion sequencer: runs one conversion and latches the result
// Assumes: Sample input holds the converter's code at the end of the conversion
// Notes:   Valid drops on start and rises only with the new result
`timescale 1ns/100ps
`include "synth_aux_defs.svh"

module sa_conv_seq #(
    parameter int CONV_CYCLES = `SA_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Control
    input  wire logic       startPulse,
    input  wire logic [6:0] sample,
    // Status
    output logic            busy,
    output logic            resultValid,
    output logic [6:0]      result,
    output logic            donePulse
);

    generate
        if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad
            $error("CONV_CYCLES out of range");
        end
    endgenerate

    localparam logic [15:0] LAST = 16'(CONV_CYCLES - 1);

    sa_pkg::sa_seq_state_t stateQ;
    logic [15:0]           countQ;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stateQ <= sa_pkg::SEQ_IDLE;
            countQ <= 16'h0000;
        end else begin
            case (stateQ)
                sa_pkg::SEQ_IDLE: begin
                    if (startPulse) begin
                        stateQ <= sa_pkg::SEQ_BUSY;
                        countQ <= 16'h0000;
                    end
                end
                sa_pkg::SEQ_BUSY: begin
                    // A repeated start restarts the count
                    if (startPulse) begin
                        countQ <= 16'h0000;
                    end else if (countQ == LAST) begin
                        stateQ <= sa_pkg::SEQ_IDLE;
                    end else begin
                        countQ <= countQ + 16'h0001;
                    end
                end
                default: stateQ <= sa_pkg::SEQ_IDLE;
            endcase
        end
    end

    wire finish = (stateQ == sa_pkg::SEQ_BUSY) && !startPulse && (countQ == LAST);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result      <= 7'h00;
            resultValid <= 1'b0;
            donePulse   <= 1'b0;
            busy        <= 1'b0;
        end else begin
            donePulse <= finish;
            busy      <= (startPulse || (stateQ == sa_pkg::SEQ_BUSY)) && !finish;
            if (startPulse) begin
                resultValid <= 1'b0;                                // [R15]
            end else if (finish) begin
                result      <= sample;
                resultValid <= 1'b1;                                // [R11] [R15]
            end
        end
    end

endmodule

// ### sa_regs_checker.sv
// Purpose: Port-level checks of the synth aux register block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Decoded outputs are checked two edges after the store
`timescale 1ns/100ps
`include "synth_aux_defs.svh"

module sa_regs_checker #(
    parameter int CONV_CYCLES = `SA_CONV_CYCLES
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Register port
    input wire logic [2:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    // Controls
    input wire logic        counterReset,
    input wire logic        refStageShutdown,
    input wire logic        dividerOff,
    input wire logic        fastLockEnable,
    input wire logic        phaseAdjustEnable,
    input wire logic        dividerAdcClock,
    input wire logic [11:0] dividerValue,
    input wire logic        tempSensorSelect,
    input wire logic        conversionBusy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic auxWr;
    logic loopWr;
    assign auxWr  = regWrite && regAddr == `SA_ADDR_AUX_CTRL && !regWdata[31];
    assign loopWr = regWrite && regAddr == `SA_ADDR_LOOP_MODE && !regWdata[31];

    a_rdata_idle: assert property (!regRead && !(regWrite && regWdata[31]) |=> regRdata == 32'h0)
        else $error("read data not zero outside a read");
    a_aux_addr: assert property (regRead && regAddr == 3'h4 |=> regRdata[2:0] == 3'h4)
        else $error("aux readback address code wrong");
    a_status_addr: assert property (regRead && regAddr == 3'h6 |=> regRdata[2:0] == 3'h6)
        else $error("status address code wrong");
    a_ref_shdn: assert property (auxWr |-> ##2 refStageShutdown == $past(regWdata[21], 2))
        else $error("reference shutdown not following store");
    a_div_mode: assert property (auxWr |-> ##2 {dividerAdcClock, phaseAdjustEnable,
        fastLockEnable, dividerOff} == (4'h1 << $past(regWdata[20:19], 2)))
        else $error("divider mode decode wrong");
    a_div_value: assert property (auxWr |-> ##2 dividerValue == $past(regWdata[18:7], 2))
        else $error("divider value wrong");
    a_cnt_reset: assert property (loopWr |-> ##2 counterReset == $past(regWdata[3], 2))
        else $error("counter reset not following store");
    a_temp_select: assert property (auxWr |-> ##2
        tempSensorSelect == ($past(regWdata[6:4], 2) == 3'h1))
        else $error("converter mode decode wrong");
    a_conv_start: assert property (auxWr && regWdata[3] && regWdata[6:4] == 3'h1
        |-> ##[1:3] conversionBusy)
        else $error("conversion did not start");
endmodule

bind synth_aux_regs sa_regs_checker #(.CONV_CYCLES(CONV_CYCLES)) sa_regs_checker_i (.*);

// ### sa_host_model.sv
// Purpose: Host controller issuing register words on the strobe port
// Assumes: Read data stands only in the cycle after the request
// Notes:   Idle address and data show the inverse of the last request
`timescale 1ns/100ps
`include "synth_aux_defs.svh"

module sa_host_model (
    // Clock and answer
    input  wire logic        sys_clk,
    input  wire logic [31:0] regRdata,
    // Request
    output logic      [2:0]  regAddr,
    output logic      [31:0] regWdata,
    output logic             regWrite,
    output logic             regRead
);
    initial begin
        regAddr  = 3'h0;
        regWdata = 32'h0;
        regWrite = 1'b0;
        regRead  = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        if (a == `SA_ADDR_AUX_CTRL) d[30:22] = 9'h0;
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask

    // Request by read strobe, or by a write word with the read bit set
    task automatic rd(input logic [2:0] a, input logic viaWr, output logic [31:0] q);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= 32'h80000000;
        if (viaWr) regWrite <= 1'b1;
        else regRead <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regRead  <= 1'b0;
        regAddr  <= ~a;
        regWdata <= 32'h7fffffff;
        // Data stand only until this edge; take them before it updates
        @(posedge sys_clk);
        q = regRdata;
    endtask
endmodule

// ### test_synth_aux_regs.sv
// Purpose: Self-checking bench of the synth aux register block
// Assumes: Conversion shortened to two cycles
// Notes:   Host model drives the port; bench drives the converter code
`timescale 1ns/100ps

module test_synth_aux_regs;
    localparam int CONV = 2;
    logic        sys_clk;
    logic        rst;
    logic [6:0]  convSample;
    logic [2:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdata;
    logic        counterReset;
    logic        refStageShutdown;
    logic        dividerOff;
    logic        fastLockEnable;
    logic        phaseAdjustEnable;
    logic        dividerAdcClock;
    logic [11:0] dividerValue;
    logic        tempSensorSelect;
    logic        conversionBusy;
    logic        irq;
    int          err_total = 0;
    int          checks_done = 0;
    logic [31:0] q;
    logic [31:0] w;

    synth_aux_regs #(.CONV_CYCLES(CONV)) synth_aux_regs_i (.*);
    sa_host_model sa_host_model_i (.*);

    always #10 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_defaults();
        chk({refStageShutdown, dividerAdcClock, phaseAdjustEnable, fastLockEnable,
            dividerOff, counterReset, dividerValue}, 32'h2000);
        sa_host_model_i.rd(3'h4, 1'b0, q);
        chk(q, 32'h4);
        sa_host_model_i.rd(3'h6, 1'b0, q);
        chk(q[11:10], 2'h2);
        chk(q[31:13], 19'h0);
        chk(q[2:0], 3'h6);
        sa_host_model_i.rd(3'h6, 1'b1, q);
        chk(q[11], 1'b0);
        sa_host_model_i.rd(3'h0, 1'b0, q);
        chk(q, 32'h0);
    endtask

    task automatic t_aux();
        for (int m = 0; m < 4; m++) begin
            w = {10'h0, 1'b1, m[1:0], (m[0] ? 12'h001 : 12'hfff), 7'h4};
            sa_host_model_i.wr(3'h4, w);
            settle();
            chk({refStageShutdown, dividerAdcClock, phaseAdjustEnable, fastLockEnable,
                dividerOff, dividerValue}, {1'b1, 4'h1 << m, w[18:7]});
            sa_host_model_i.rd(3'h4, m[0], q);
            chk(q, w);
        end
    endtask

    task automatic t_loop_and_ro();
        sa_host_model_i.wr(3'h3, 32'h4b);
        settle();
        chk(counterReset, 1'b1);
        sa_host_model_i.wr(3'h3, 32'h43);
        settle();
        chk(counterReset, 1'b0);
        sa_host_model_i.rd(3'h6, 1'b0, w);
        sa_host_model_i.wr(3'h6, 32'h00000ffe);
        sa_host_model_i.rd(3'h6, 1'b0, q);
        chk(q, w);
    endtask

    task automatic t_conv();
        sa_host_model_i.wr(3'h7, 32'h1);
        convSample <= 7'h5a;
        sa_host_model_i.wr(3'h4, 32'h18);
        sa_host_model_i.rd(3'h6, 1'b0, q);
        chk(q[10], 1'b0);
        repeat (CONV + 4) @(posedge sys_clk);
        #1 chk(irq, 1'b1);
        sa_host_model_i.rd(3'h6, 1'b0, q);
        chk(q[11:3], {2'h1, 7'h5a});
        sa_host_model_i.wr(3'h5, 32'h1);
        settle();
        chk(irq, 1'b0);
        sa_host_model_i.wr(3'h7, 32'h0);
        convSample <= 7'h25;
        sa_host_model_i.wr(3'h4, 32'h18);
        sa_host_model_i.rd(3'h6, 1'b1, q);
        chk(q[10], 1'b0);
        repeat (CONV + 4) @(posedge sys_clk);
        #1 chk(irq, 1'b0);
        sa_host_model_i.rd(3'h6, 1'b0, q);
        chk(q[10:3], {1'b1, 7'h25});
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        sys_clk    = 1'b0;
        rst        = 1'b1;
        convSample = 7'h0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        t_defaults();
        t_aux();
        t_loop_and_ro();
        t_conv();
        finish_test();
    end
endmodule
